// ### bus_matrix_pkg.sv
// Purpose: constants for the four-master, five-slave bus matrix and DMA prioritiser
// Assumes: one clock (master_clock), synchronous active-low reset
// Notes: address map windows are plain defaults, same for every master
//
// Functional notes
// - Four masters, each accessing slaves concurrently.
// - Per-master decoder, all sharing one address map.
// - Five slaves, each with its own arbiter.
// - Processor buses wired only to their slaves.
// - DMA skips flash; CRC skips bridge.
// - Bridge peripherals run on master_clock.
// - DMA engine is a matrix master for channels.
// - Memory-to-peripheral transfer costs one cycle.
// - Peripheral-to-memory transfer costs two cycles.
// - Thirteen low slots rank lowest, fixed order; all transmit but channel 1 (receive).
// - Receive channels 13..23 rank above; card_host receive highest.
// - Channel reloads next pointer and count at end.
package bus_matrix_pkg;
    // --------------------------------------------------------------
    // Matrix dimensions
    // --------------------------------------------------------------
    localparam int N_MST = 4;
    localparam int N_SLV = 5;
    localparam int N_CH = 24;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;

    // Slave indices
    localparam int S_SRAM = 0;
    localparam int S_ROM = 1;
    localparam int S_FLASH = 2;
    localparam int S_EBI = 3;
    localparam int S_BRIDGE = 4;

    // Access map, bit s of entry m set when master m wired to slave s
    localparam logic [4:0] ACCESS_M0 = 5'h06;
    localparam logic [4:0] ACCESS_M1 = 5'h19;
    localparam logic [4:0] ACCESS_M2 = 5'h1B;
    localparam logic [4:0] ACCESS_M3 = 5'h0F;

    // Address windows by top nibble (defaults)
    localparam logic [3:0] REGION_CODE = 4'h0;
    localparam logic [3:0] REGION_SRAM = 4'h2;
    localparam logic [3:0] REGION_PERIPH = 4'h4;
    localparam logic [3:0] REGION_EBI = 4'h6;
    localparam logic [11:0] ROM_BASE_HI = 12'h008;

    // DMA transfer cost in master_clock cycles
    localparam logic [1:0] MEM2PER_CYCLES = 2'h1;
    localparam logic [1:0] PER2MEM_CYCLES = 2'h2;

    // Bit index = priority, 23 top; slots 0..12 transmit except channel 1 (receive), 13..23 receive
    localparam logic [23:0] CH_IS_RX = 24'hFFE002;

    typedef enum logic [1:0] {
        DMA_IDLE = 2'b00,
        DMA_XFER = 2'b01,
        DMA_WAIT = 2'b10
    } dma_state_t;
endpackage

// ### bus_matrix.sv
// Purpose: multi-layer bus matrix with per-slave arbiters and DMA channel prioritiser
// Assumes: slaves answer with a one-cycle ready; one master_clock for all
// Notes: master 2 request is generated internally by the DMA engine
`timescale 1ns/1ps
module bus_matrix
    import bus_matrix_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // External masters 0,1,3 (index 2 port unused, driven by DMA)
    input wire logic [N_MST-1:0] m_req,
    input wire logic [N_MST*ADDR_W-1:0] m_addr,
    input wire logic [N_MST-1:0] m_write,
    input wire logic [N_MST*DATA_W-1:0] m_wdata,
    output logic [N_MST-1:0] m_done,
    output logic [N_MST-1:0] m_err,
    output logic [N_MST*DATA_W-1:0] m_rdata,
    // Slave side
    output logic [N_SLV-1:0] s_sel,
    output logic [N_SLV*ADDR_W-1:0] s_addr,
    output logic [N_SLV-1:0] s_write,
    output logic [N_SLV*DATA_W-1:0] s_wdata,
    input wire logic [N_SLV-1:0] s_ready,
    input wire logic [N_SLV*DATA_W-1:0] s_rdata,
    // Bridge peripheral clock
    output logic periph_clk_en,
    // DMA channels
    input wire logic [N_CH-1:0] ch_req,
    input wire logic [N_CH-1:0] ch_next_load,
    input wire logic [N_CH*ADDR_W-1:0] ch_next_ptr,
    input wire logic [N_CH*CNT_W-1:0] ch_next_cnt,
    input wire logic [N_CH*ADDR_W-1:0] ch_periph_addr,
    output logic [N_CH-1:0] ch_ack,
    output logic [N_CH-1:0] ch_end
);
    // ------------------------------------------------------------
    // Decoders: one per master, same map
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] maddr [N_MST];
    logic [N_SLV-1:0] dec [N_MST]; // One-hot slave hit
    logic [N_SLV-1:0] wired [N_MST];
    logic [N_MST-1:0] req_all;
    logic [N_MST-1:0] bad; // Unwired or unmapped
    logic [ADDR_W-1:0] dma_addr_r;
    logic dma_req_r;
    logic dma_write_r;
    logic [DATA_W-1:0] dma_data_r;

    assign wired[0] = ACCESS_M0;
    assign wired[1] = ACCESS_M1;
    assign wired[2] = ACCESS_M2;
    assign wired[3] = ACCESS_M3;

    // Decode applies the identical address map to every master's own address
    always_comb begin
        for (int m = 0; m < N_MST; m++) begin
            maddr[m] = (m == 2) ? dma_addr_r : m_addr[m*ADDR_W +: ADDR_W];
            // DMA request masked while its answer shows, else the held request starts a second access
            req_all[m] = (m == 2) ? (dma_req_r && !m_done[2] && !m_err[2]) : m_req[m];
            dec[m] = '0;
            unique case (maddr[m][31:28])
                REGION_CODE: begin
                    if (maddr[m][31:20] == ROM_BASE_HI) begin
                        dec[m][S_ROM] = 1'b1;
                    end else begin
                        dec[m][S_FLASH] = 1'b1;
                    end
                end
                REGION_SRAM: dec[m][S_SRAM] = 1'b1;
                REGION_PERIPH: dec[m][S_BRIDGE] = 1'b1;
                REGION_EBI: dec[m][S_EBI] = 1'b1;
                default: dec[m] = '0;
            endcase
            bad[m] = req_all[m] && ((dec[m] & wired[m]) == '0);
        end
    end

    // ------------------------------------------------------------
    // Per-slave arbiters: round robin, owner held until ready
    // ------------------------------------------------------------
    logic [1:0] owner_r [N_SLV];
    logic [N_SLV-1:0] busy_r;
    logic [N_SLV-1:0] xfer_done;
    logic [1:0] pick [N_SLV];
    logic [N_SLV-1:0] any;

    // Each slave independently chooses the next master after last owner
    always_comb begin
        for (int s = 0; s < N_SLV; s++) begin
            any[s] = 1'b0;
            pick[s] = owner_r[s];
            for (int k = 4; k >= 1; k--) begin
                if (req_all[2'(owner_r[s] + 2'(k))] && dec[2'(owner_r[s] + 2'(k))][s]
                    && wired[2'(owner_r[s] + 2'(k))][s]) begin
                    any[s] = 1'b1;
                    pick[s] = 2'(owner_r[s] + 2'(k));
                end
            end
            xfer_done[s] = busy_r[s] && s_ready[s];
        end
    end

    // Owner and busy flag per slave
    always_ff @(posedge core_clk) begin
        for (int s = 0; s < N_SLV; s++) begin
            if (!rst_b) begin
                owner_r[s] <= 2'h3;
                busy_r[s] <= 1'b0;
            end else if (xfer_done[s] || (!busy_r[s] && any[s])) begin
                busy_r[s] <= !busy_r[s];
                if (!busy_r[s]) begin
                    owner_r[s] <= pick[s];
                end
            end
        end
    end

    // Slave drive: registered from the chosen master
    always_ff @(posedge core_clk) begin
        for (int s = 0; s < N_SLV; s++) begin
            if (!rst_b) begin
                s_sel[s] <= 1'b0;
                s_write[s] <= 1'b0;
                s_addr[s*ADDR_W +: ADDR_W] <= '0;
                s_wdata[s*DATA_W +: DATA_W] <= '0;
            end else if (!busy_r[s] && any[s]) begin
                s_sel[s] <= 1'b1;
                s_addr[s*ADDR_W +: ADDR_W] <= maddr[pick[s]];
                s_write[s] <= (pick[s] == 2'h2) ? dma_write_r : m_write[pick[s]];
                s_wdata[s*DATA_W +: DATA_W] <= (pick[s] == 2'h2) ? dma_data_r
                                                : m_wdata[pick[s]*DATA_W +: DATA_W];
            end else if (xfer_done[s]) begin
                s_sel[s] <= 1'b0;
            end
        end
    end

    // Master answers: done and error as one-cycle pulses, read data held until the next completion
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            m_done <= '0;
            m_err <= '0;
            m_rdata <= '0;
        end else begin
            for (int m = 0; m < N_MST; m++) begin
                m_done[m] <= 1'b0;
                m_err[m] <= bad[m] && !m_err[m];
                for (int s = 0; s < N_SLV; s++) begin
                    if (xfer_done[s] && owner_r[s] == 2'(m)) begin
                        m_done[m] <= 1'b1;
                        m_rdata[m*DATA_W +: DATA_W] <= s_rdata[s*DATA_W +: DATA_W];
                    end
                end
            end
        end
    end

    // Bridge peripherals share the matrix clock, enable on from the cycle after reset
    always_ff @(posedge core_clk) begin
        periph_clk_en <= rst_b;
    end

    // ------------------------------------------------------------
    // DMA engine: priority pick, one transfer at a time
    // ------------------------------------------------------------
    dma_state_t st_r;
    logic [4:0] cur_r;
    logic [4:0] win;
    logic win_ok;
    logic [1:0] wait_r;
    logic [ADDR_W-1:0] ptr_r [N_CH];
    logic [CNT_W-1:0] cnt_r [N_CH];
    logic [ADDR_W-1:0] nptr_r [N_CH];
    logic [CNT_W-1:0] ncnt_r [N_CH];
    logic [N_CH-1:0] ready_ch;

    // Highest index wins: slots 0..12 low (channel 1 receive), receive 13..23 high
    always_comb begin
        win = '0;
        win_ok = 1'b0;
        for (int c = 0; c < N_CH; c++) begin
            ready_ch[c] = ch_req[c] && (cnt_r[c] != '0);
            if (ready_ch[c]) begin
                win = 5'(c);
                win_ok = 1'b1;
            end
        end
    end

    // Sequencer: issue to matrix then account bus cycles
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r <= DMA_IDLE;
            cur_r <= '0;
            wait_r <= '0;
            dma_req_r <= 1'b0;
            dma_write_r <= 1'b0;
            dma_addr_r <= '0;
            dma_data_r <= '0;
        end else begin
            unique case (st_r)
                DMA_IDLE: begin
                    if (win_ok) begin
                        cur_r <= win;
                        dma_req_r <= 1'b1;
                        // Receive writes memory, transmit reads memory
                        dma_write_r <= CH_IS_RX[win];
                        dma_addr_r <= ptr_r[win];
                        dma_data_r <= ch_periph_addr[win*ADDR_W +: ADDR_W];
                        wait_r <= CH_IS_RX[win] ? PER2MEM_CYCLES : MEM2PER_CYCLES;
                        st_r <= DMA_XFER;
                    end
                end
                DMA_XFER: begin
                    if (m_done[2] || m_err[2]) begin
                        dma_req_r <= 1'b0;
                        st_r <= DMA_WAIT;
                    end
                end
                DMA_WAIT: begin
                    wait_r <= wait_r - 2'h1;
                    if (wait_r <= 2'h1) begin
                        st_r <= DMA_IDLE;
                    end
                end
                default: st_r <= DMA_IDLE;
            endcase
        end
    end

    // Channel pointers with next-buffer reload
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ch_ack <= '0;
            ch_end <= '0;
            for (int c = 0; c < N_CH; c++) begin
                ptr_r[c] <= '0;
                cnt_r[c] <= '0;
                nptr_r[c] <= '0;
                ncnt_r[c] <= '0;
            end
        end else begin
            ch_ack <= '0;
            ch_end <= '0;
            for (int c = 0; c < N_CH; c++) begin
                if (ch_next_load[c]) begin
                    nptr_r[c] <= ch_next_ptr[c*ADDR_W +: ADDR_W];
                    ncnt_r[c] <= ch_next_cnt[c*CNT_W +: CNT_W];
                end
                if (cnt_r[c] == '0 && ncnt_r[c] != '0 && !ch_next_load[c]) begin
                    ptr_r[c] <= nptr_r[c];
                    cnt_r[c] <= ncnt_r[c];
                    ncnt_r[c] <= '0;
                end
            end
            if (st_r == DMA_XFER && m_done[2]) begin
                ch_ack[cur_r] <= 1'b1;
                ptr_r[cur_r] <= ptr_r[cur_r] + 32'h4;
                cnt_r[cur_r] <= cnt_r[cur_r] - 16'h1;
                if (cnt_r[cur_r] == 16'h1 && ncnt_r[cur_r] == '0) begin
                    ch_end[cur_r] <= 1'b1;
                end
            end
        end
    end
endmodule

// ### bus_matrix_chk.sv
// Purpose: port-level assertions for the bus matrix
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/1ps
module bus_matrix_chk
    import bus_matrix_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Master side
    input wire logic [N_MST-1:0] m_req,
    input wire logic [N_MST*ADDR_W-1:0] m_addr,
    input wire logic [N_MST-1:0] m_done,
    input wire logic [N_MST-1:0] m_err,
    // Slave side and status
    input wire logic [N_SLV-1:0] s_sel,
    input wire logic [N_SLV-1:0] s_ready,
    input wire logic periph_clk_en,
    input wire logic [N_CH-1:0] ch_ack
);
    // --------------------------------------------------------------
    // Shared clocking
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // New requests on unwired paths; error flag low so a held request is not double counted
    sequence m0_sram_s;
        m_req[0] && !m_err[0] && m_addr[31:28] == 4'h2;
    endsequence
    sequence m1_rom_s;
        m_req[1] && !m_err[1] && m_addr[63:52] == 12'h008;
    endsequence
    sequence m3_bridge_s;
        m_req[3] && !m_err[3] && m_addr[127:124] == 4'h4;
    endsequence

    m0_refuse_a: assert property (m0_sram_s |=> m_err[0]) else $error("m0 to sram not refused");
    m1_refuse_a: assert property (m1_rom_s |=> m_err[1]) else $error("m1 to rom not refused");
    m3_refuse_a: assert property (m3_bridge_s |=> m_err[3]) else $error("m3 to bridge not refused");
    // Completion must follow a ready from a wired slave only
    m0_done_a: assert property (m_done[0] |-> $past(s_ready[1] || s_ready[2])) else $error("m0 done bad");
    m1_done_a: assert property (m_done[1] |-> $past(s_ready[0] || s_ready[3] || s_ready[4]))
        else $error("m1 done bad");
    m3_done_a: assert property (m_done[3] |-> $past(|s_ready[3:0])) else $error("m3 done bad");
    sel_drop_a: assert property (s_sel[0] && s_ready[0] |=> !s_sel[0]) else $error("sram select held");
    clk_en_a: assert property ($past(rst_b) |-> periph_clk_en) else $error("bridge clock off");
    one_ack_a: assert property ($onehot0(ch_ack)) else $error("two channels served");
endmodule

// ### slave_model.sv
// Purpose: behavioural memory slaves answering the matrix
// Assumes: one ready pulse per access, wait set by dly
// Notes: read data is address xor KEY; idle data toggles every cycle
`timescale 1ns/1ps
module slave_model
    import bus_matrix_pkg::*;
#(
    parameter logic [31:0] KEY = 32'h5A5A0000
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Matrix slave side
    input wire logic [N_SLV-1:0] s_sel,
    input wire logic [N_SLV*ADDR_W-1:0] s_addr,
    input wire logic [1:0] dly,
    output logic [N_SLV-1:0] s_ready,
    output logic [N_SLV*DATA_W-1:0] s_rdata
);
    logic [1:0] wait_r [N_SLV]; // Wait states spent per slave

    // Answer each select dly+1 cycles after it rises; stale data never looks valid
    always_ff @(posedge core_clk) begin
        for (int s = 0; s < N_SLV; s++) begin
            s_ready[s] <= 1'h0;
            s_rdata[s*DATA_W+:DATA_W] <= ~s_rdata[s*DATA_W+:DATA_W];
            if (!rst_b) begin
                wait_r[s] <= 2'h0;
                s_rdata[s*DATA_W+:DATA_W] <= 32'h0;
            end else if (s_sel[s] && !s_ready[s]) begin
                if (wait_r[s] == dly) begin
                    s_ready[s] <= 1'h1;
                    s_rdata[s*DATA_W+:DATA_W] <= s_addr[s*ADDR_W+:ADDR_W] ^ KEY;
                    wait_r[s] <= 2'h0;
                end else begin
                    wait_r[s] <= wait_r[s] + 2'h1;
                end
            end
        end
    end
endmodule

// ### test_bus_matrix_with_dma_priority.sv
// Purpose: self-checking bench for the bus matrix and DMA prioritiser
// Assumes: slave_model answers; masters 0, 1 and 3 driven here
// Notes: requests drop at the ready edge so no second access starts
`timescale 1ns/1ps
module test_bus_matrix_with_dma_priority
    import bus_matrix_pkg::*;
;
    localparam logic [31:0] KEY = 32'h5A5A0000; // Slave read data mask
    logic core_clk, rst_b, periph_clk_en;
    logic [N_MST-1:0] m_req, m_write, m_done, m_err;
    logic [N_MST*ADDR_W-1:0] m_addr;
    logic [N_MST*DATA_W-1:0] m_wdata, m_rdata;
    logic [N_SLV-1:0] s_sel, s_write, s_ready;
    logic [N_SLV*ADDR_W-1:0] s_addr;
    logic [N_SLV*DATA_W-1:0] s_wdata, s_rdata;
    logic [N_CH-1:0] ch_req, ch_next_load, ch_ack, ch_end;
    logic [N_CH*ADDR_W-1:0] ch_next_ptr, ch_periph_addr;
    logic [N_CH*CNT_W-1:0] ch_next_cnt;
    logic [1:0] dly;
    int n_mismatch = 0;
    int tests_run = 0;

    bus_matrix i_dut (.core_clk, .rst_b, .m_req, .m_addr, .m_write, .m_wdata, .m_done, .m_err, .m_rdata,
        .s_sel, .s_addr, .s_write, .s_wdata, .s_ready, .s_rdata, .periph_clk_en, .ch_req, .ch_next_load,
        .ch_next_ptr, .ch_next_cnt, .ch_periph_addr, .ch_ack, .ch_end);
    slave_model #(.KEY(KEY)) i_slv (.core_clk, .rst_b, .s_sel, .s_addr, .dly, .s_ready, .s_rdata);

    // Free-running 100 MHz clock
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        n_mismatch++;
        $display("[FAIL] %0t timeout", $time);
        report_and_stop();
    endtask

    // One wired access, held until the slave's ready edge
    task automatic acc(input int m, input int s, input logic [31:0] a, input logic w);
        int n;
        @(posedge core_clk);
        m_req[m] <= 1'h1;
        m_addr[m*32+:32] <= a;
        m_write[m] <= w;
        m_wdata[m*32+:32] <= ~a;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (s_ready[s] !== 1'h1 && n < 40);
        if (n >= 40) hang();
        m_req[m] <= 1'h0;
        chk(s_addr[s*32+:32], a);
        chk({31'h0, s_write[s]}, {31'h0, w});
        if (w) chk(s_wdata[s*32+:32], ~a);
        @(negedge core_clk);
        chk({31'h0, m_done[m]}, 32'h1);
        if (!w) chk(m_rdata[m*32+:32], a ^ KEY);
    endtask

    // One-cycle request on a refused path
    task automatic bad(input int m, input logic [31:0] a);
        int n;
        @(posedge core_clk);
        m_req[m] <= 1'h1;
        m_addr[m*32+:32] <= a;
        m_write[m] <= 1'h0;
        @(posedge core_clk);
        m_req[m] <= 1'h0;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (m_err[m] !== 1'h1 && n < 4);
        chk({31'h0, m_err[m]}, 32'h1);
    endtask

    task automatic t_paths();
        int mt[9] = '{0, 0, 1, 1, 1, 3, 3, 3, 3};
        int st[9] = '{1, 2, 0, 3, 4, 0, 1, 2, 3};
        logic [31:0] at[9] = '{32'h00800010, 32'h00000100, 32'h20000004, 32'h60000020, 32'h40000008,
            32'h20000040, 32'h00800400, 32'h00010000, 32'h60000100};
        for (int i = 0; i < 9; i++) acc(mt[i], st[i], at[i], i[0]);
    endtask

    task automatic t_refuse();
        int mt[7] = '{0, 0, 0, 1, 1, 3, 0};
        logic [31:0] at[7] = '{32'h20000000, 32'h60000000, 32'h40000000, 32'h00800000, 32'h00000000,
            32'h40000000, 32'hF0000000};
        for (int i = 0; i < 7; i++) bad(mt[i], at[i]);
    endtask

    // Three masters at once on slow slaves, then an error beside a good access
    task automatic t_conc();
        dly <= 2'h2;
        fork
            acc(0, 2, 32'h00000200, 1'h0);
            acc(1, 3, 32'h60000040, 1'h1);
            acc(3, 0, 32'h20000080, 1'h0);
        join
        fork
            bad(3, 32'h40000010);
            acc(1, 4, 32'h40000010, 1'h0);
        join
        dly <= 2'h0;
    endtask

    // Channels 23, 13 and 0 compete; channel 0 has a second buffer queued
    task automatic t_dma();
        int q[$];
        int t[$];
        int e0;
        logic [N_CH-1:0] endm;
        logic [31:0] fa;
        e0 = 0;
        endm = '0;
        fa = 32'h0;
        foreach (q[i]) q.delete();
        @(posedge core_clk);
        for (int c = 0; c < 24; c += 13) begin
            ch_next_ptr[c*32+:32] <= 32'h20001000 + c * 16;
            ch_next_cnt[c*16+:16] <= 16'h1;
        end
        ch_next_ptr[23*32+:32] <= 32'h20001170;
        ch_next_cnt[23*16+:16] <= 16'h1;
        ch_next_load <= 24'h802001;
        @(posedge core_clk);
        ch_next_load <= 24'h0;
        @(posedge core_clk);
        ch_next_load <= 24'h000001;
        @(posedge core_clk);
        ch_next_load <= 24'h0;
        ch_req <= 24'h802001;
        for (int k = 0; k < 300; k++) begin
            @(negedge core_clk);
            for (int c = 0; c < N_CH; c++) if (ch_ack[c] === 1'h1) begin
                q.push_back(c);
                t.push_back(k);
            end
            if (s_sel[0] === 1'h1 && fa == 32'h0) fa = s_addr[31:0];
            endm |= ch_end;
            e0 += ch_end[0];
        end
        @(posedge core_clk);
        ch_req <= 24'h0;
        if (q.size() != 4) hang();
        chk(fa, 32'h20001170);
        chk(q[0], 23);
        chk(q[1], 13);
        chk(q[2], 0);
        chk(t[2] - t[1], t[1] - t[0]);
        chk(t[3] - t[2] + 1, t[2] - t[1]);
        chk(q[3], 0);
        chk(endm, 32'h802001);
        chk(e0, 1);
    endtask

    // Channel 1 sits among the low slots but receives, so its word is a memory write
    task automatic t_rx1();
        int n;
        @(posedge core_clk);
        ch_next_ptr[1*32+:32] <= 32'h20002000;
        ch_next_cnt[1*16+:16] <= 16'h1;
        ch_next_load <= 24'h000002;
        @(posedge core_clk);
        ch_next_load <= 24'h0;
        ch_req <= 24'h000002;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (s_sel[0] !== 1'h1 && n < 20);
        chk({31'h0, s_write[0]}, 32'h1);
        chk(s_addr[31:0], 32'h20002000);
        @(posedge core_clk);
        ch_req <= 24'h0;
    endtask

    initial begin
        rst_b = 1'h0;
        m_req = '0;
        m_addr = '0;
        m_write = '0;
        m_wdata = '0;
        ch_req = '0;
        ch_next_load = '0;
        ch_next_ptr = '0;
        ch_next_cnt = '0;
        ch_periph_addr = {N_CH{32'hC0DE0000}};
        dly = 2'h0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge core_clk);
        chk({31'h0, periph_clk_en}, 32'h1);
        t_paths();
        t_refuse();
        t_conc();
        t_dma();
        t_rx1();
        report_and_stop();
    end
endmodule

bind bus_matrix bus_matrix_chk i_chk (.core_clk(core_clk), .rst_b(rst_b), .m_req(m_req), .m_addr(m_addr),
    .m_done(m_done), .m_err(m_err), .s_sel(s_sel), .s_ready(s_ready), .periph_clk_en(periph_clk_en),
    .ch_ack(ch_ack));
